//--- pgw_watchdog.sv
// Purpose: 8-bit watchdog / interval timer with password word writes
// Assumes: One access per cycle; a byte write never raises wrWord
// Notes:   chipResetOut_b feeds the chip reset tree, not rst_b
//
// Overview of operation
// - Only word writes update counter and control
// - High 5A loads counter, A5 loads control
// - A5 with 00 clears watchdog reset flag
// - High 5A copies data bit into output enable
// - Byte reads at C, D and F addresses
// - Watchdog overflow resets chip for 518 states
// - Enabled output pin drives low 132 states
// - Watchdog flag tells watchdog from pin reset
// - Simultaneous pin reset wins over watchdog
// - Interval mode overflow requests interrupt
// - Overflow flag set with reset or interrupt
// - Watchdog flag set only in watchdog mode
// - Internal reset keeps watchdog flag, clears overflow
// - Counter write beats a coincident increment
// - Counter counts when enabled, else held zero
// - Clock select picks divide 2 to 4096
// - Overflow flag clears by read one, write zero
// - Watchdog flag and enable reset only by pin
`timescale 1ns/100ps
module pgw_watchdog (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire pgw_pkg::pgw_bus_t cpuBus,
	output logic [7:0]            rdData,
	output logic                  intervalOverflowIrq,
	output logic                  chipResetOut_b,
	output logic                  resetOutPinOut,
	output logic                  resetOutPinOe
);

	////////////////////////////////////////////////////////////////////////////
	// Divider tap for a clock-select code
	function automatic logic [3:0] tapOf(input logic [2:0] sel);
		case (sel)
			3'h0:    tapOf = 4'h0;
			3'h1:    tapOf = 4'h4;
			3'h2:    tapOf = 4'h5;
			3'h3:    tapOf = 4'h6;
			3'h4:    tapOf = 4'h7;
			3'h5:    tapOf = 4'h8;
			3'h6:    tapOf = 4'hA;
			default: tapOf = 4'hB;
		endcase
	endfunction

	logic [7:0]              cnt_r, cnt_nxt;
	logic                    flag_r, flag_nxt, mode_r, ena_r;
	logic [2:0]              sel_r;
	logic                    watchdog_reset_flag_r, watchdog_reset_flag_nxt, oe_r;
	logic                    flagSeen_r;
	logic [pgw_pkg::PRE_W-1:0] pre_r;
	logic                    tick_r;
	logic [9:0]              rstCnt_r;
	logic [9:0]              pinCnt_r;
	pgw_pkg::pgw_state_t     state_r;
	logic                    intRst_r;

	////////////////////////////////////////////////////////////////////////////
	// Password decode of word writes
	wire wrCtlAddr = cpuBus.wrWord && cpuBus.addr == pgw_pkg::ADDR_CTRL_WR;
	wire wrRstAddr = cpuBus.wrWord && cpuBus.addr == pgw_pkg::ADDR_RST_WR;
	wire [7:0] hiB = cpuBus.wdata[15:8];
	wire [7:0] loB = cpuBus.wdata[7:0];
	wire wrCnt     = wrCtlAddr && hiB == pgw_pkg::PASS_CNT;
	wire wrCtl     = wrCtlAddr && hiB == pgw_pkg::PASS_CTRL;
	wire clrWrst   = wrRstAddr && hiB == pgw_pkg::PASS_CTRL && loB == pgw_pkg::CLR_DATA;
	wire wrOe      = wrRstAddr && hiB == pgw_pkg::PASS_CNT;
	wire rdCtl     = cpuBus.rdByte && cpuBus.addr == pgw_pkg::ADDR_CTRL_RD;

	////////////////////////////////////////////////////////////////////////////
	// Count enable, overflow and flag updates
	wire [3:0] tap   = tapOf(sel_r);
	wire       tickNow = pre_r[tap];
	wire       tickEdge = tickNow && !tick_r;
	wire       ovf   = ena_r && tickEdge && !wrCnt && cnt_r == pgw_pkg::CNT_MAX;
	wire       wdOvf = ovf && mode_r;

	always_comb begin
		if (!ena_r) begin
			cnt_nxt = pgw_pkg::CNT_RESET;
		end else if (wrCnt) begin
			cnt_nxt = loB;
		end else if (tickEdge) begin
			cnt_nxt = cnt_r + 8'h01;
		end else begin
			cnt_nxt = cnt_r;
		end
		flag_nxt = flag_r;
		if (wrCtl && !loB[pgw_pkg::BIT_FLAG] && flagSeen_r) begin
			flag_nxt = 1'b0;
		end
		if (ovf) begin
			flag_nxt = 1'b1;
		end
		watchdog_reset_flag_nxt = clrWrst ? 1'b0 : watchdog_reset_flag_r;
		if (wdOvf) begin
			watchdog_reset_flag_nxt = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timer registers, cleared by pin reset and by the internal reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r      <= pgw_pkg::CNT_RESET;
			flag_r     <= 1'b0;
			mode_r     <= 1'b0;
			ena_r      <= 1'b0;
			sel_r      <= 3'h0;
			flagSeen_r <= 1'b0;
			pre_r      <= '0;
			tick_r     <= 1'b0;
		end else if (intRst_r) begin
			cnt_r      <= pgw_pkg::CNT_RESET;
			flag_r     <= 1'b0;
			mode_r     <= 1'b0;
			ena_r      <= 1'b0;
			sel_r      <= 3'h0;
			flagSeen_r <= 1'b0;
			pre_r      <= '0;
			tick_r     <= 1'b0;
		end else begin
			cnt_r      <= cnt_nxt;
			flag_r     <= flag_nxt;
			if (wrCtl) begin
				mode_r <= loB[pgw_pkg::BIT_MODE];
				ena_r  <= loB[pgw_pkg::BIT_ENA];
				sel_r  <= loB[2:0];
			end
			flagSeen_r <= (rdCtl && flag_r) ? 1'b1 : (flag_nxt ? flagSeen_r : 1'b0);
			pre_r      <= ena_r ? pre_r + 1'b1 : '0;
			tick_r     <= tickNow;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin-reset-only flags; pin reset overrides a same-cycle overflow
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_reset_flag_r <= 1'b0;
			oe_r   <= 1'b0;
		end else begin
			watchdog_reset_flag_r <= watchdog_reset_flag_nxt;
			if (wrOe) begin
				oe_r <= loB[pgw_pkg::BIT_OE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset pulse sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r  <= pgw_pkg::PGW_RUN;
			rstCnt_r <= '0;
			pinCnt_r <= '0;
			intRst_r <= 1'b0;
		end else begin
			case (state_r)
				pgw_pkg::PGW_RUN: begin
					if (wdOvf) begin
						state_r  <= pgw_pkg::PGW_RESET;
						intRst_r <= 1'b1;
						rstCnt_r <= pgw_pkg::CHIP_RESET_CNT - 10'h001;
						pinCnt_r <= oe_r ? pgw_pkg::PIN_RESET_CNT : 10'h000;
					end
				end
				pgw_pkg::PGW_RESET: begin
					if (pinCnt_r != 10'h000) begin
						pinCnt_r <= pinCnt_r - 10'h001;
					end
					if (rstCnt_r == 10'h000) begin
						state_r  <= pgw_pkg::PGW_RUN;
						intRst_r <= 1'b0;
					end else begin
						rstCnt_r <= rstCnt_r - 10'h001;
					end
				end
				default: begin
					state_r  <= pgw_pkg::PGW_RUN;
					intRst_r <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	wire [7:0] ctlView = {flag_r, mode_r, ena_r, 2'b00, sel_r} | pgw_pkg::CTRL_RESERVED;
	wire [7:0] rstView = {watchdog_reset_flag_r, oe_r, 6'h00} | pgw_pkg::RST_RESERVED;
	wire [7:0] rdMux   = !cpuBus.rdByte ? 8'h00 :
	                     cpuBus.addr == pgw_pkg::ADDR_CTRL_RD ? ctlView :
	                     cpuBus.addr == pgw_pkg::ADDR_CNT_RD  ? cnt_r :
	                     cpuBus.addr == pgw_pkg::ADDR_RST_RD  ? rstView : 8'h00;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData              <= 8'h00;
			intervalOverflowIrq <= 1'b0;
			chipResetOut_b      <= 1'b1;
			resetOutPinOut      <= 1'b0;
			resetOutPinOe       <= 1'b0;
		end else begin
			rdData              <= rdMux;
			// One pulse per overflow event, not a level while the flag stands
			intervalOverflowIrq <= ovf && !mode_r;
			chipResetOut_b      <= !(wdOvf || (intRst_r && rstCnt_r != 10'h000));
			resetOutPinOut      <= 1'b0;
			resetOutPinOe       <= (state_r == pgw_pkg::PGW_RUN) ? (wdOvf && oe_r)
			                       : (pinCnt_r > 10'h001);
		end
	end

endmodule

//--- pgw_pkg.sv
// Purpose: Shared constants and types for the password guarded watchdog
// Assumes: 20-bit internal byte address, 16-bit write data bus
// Notes:   Register addresses are the printed ones
package pgw_pkg;

	localparam logic [19:0] ADDR_CTRL_WR  = 20'hFFF8C;
	localparam logic [19:0] ADDR_RST_WR   = 20'hFFF8E;
	localparam logic [19:0] ADDR_CTRL_RD  = 20'hFFF8C;
	localparam logic [19:0] ADDR_CNT_RD   = 20'hFFF8D;
	localparam logic [19:0] ADDR_RST_RD   = 20'hFFF8F;

	localparam logic [7:0]  PASS_CNT      = 8'h5A;
	localparam logic [7:0]  PASS_CTRL     = 8'hA5;
	localparam logic [7:0]  CLR_DATA      = 8'h00;
	localparam logic [7:0]  CNT_RESET     = 8'h00;
	localparam logic [7:0]  CNT_MAX       = 8'hFF;
	localparam logic [7:0]  CTRL_RESERVED = 8'h18;
	localparam logic [7:0]  RST_RESERVED  = 8'h3F;

	localparam int BIT_FLAG = 7;
	localparam int BIT_MODE = 6;
	localparam int BIT_ENA  = 5;
	localparam int BIT_OE   = 6;

	// Pulse lengths in states (one state is one clock)
	localparam int CHIP_RESET_STATES = 518;
	localparam int PIN_RESET_STATES  = 132;
	localparam logic [9:0] CHIP_RESET_CNT = 10'(CHIP_RESET_STATES);
	localparam logic [9:0] PIN_RESET_CNT  = 10'(PIN_RESET_STATES);

	localparam int PRE_W = 12;

	// CPU access bundle
	typedef struct packed {
		logic        wrWord;
		logic        rdByte;
		logic [19:0] addr;
		logic [15:0] wdata;
	} pgw_bus_t;

	typedef enum logic [1:0] {
		PGW_RUN     = 2'b00,
		PGW_RESET   = 2'b01
	} pgw_state_t;

endpackage

//--- pgw_cpu_model.sv
// Purpose: CPU side model that issues word writes and byte reads
// Assumes: One request at a time, driven just after a rising edge
// Notes:   Idle bus shows inverted address and data, strobes low
`timescale 1ns/100ps
module pgw_cpu_model (
	input  wire logic        clk,
	input  wire logic [7:0]  rdData,
	output pgw_pkg::pgw_bus_t cpuBus
);
	// Bus starts idle
	initial cpuBus = '0;

	// Word write, taken at the second edge; no byte writes exist
	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge clk);
		cpuBus <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		cpuBus <= '{1'b0, 1'b0, ~a, ~d};
	endtask

	// Byte read, data picked up one cycle after the taking edge
	task automatic rd(input logic [19:0] a, output logic [7:0] v);
		@(posedge clk);
		cpuBus <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		cpuBus <= '{1'b0, 1'b0, ~a, 16'hFFFF};
		@(posedge clk);
		v = rdData;
	endtask
endmodule

//--- pgw_watchdog_properties.sv
// Purpose: Port level checks of the watchdog
// Assumes: Bound onto every pgw_watchdog
// Notes:   Pulse lengths are counted in helper registers
`timescale 1ns/100ps
module pgw_watchdog_properties (
	input wire logic              clk,
	input wire logic              rst_b,
	input wire pgw_pkg::pgw_bus_t cpuBus,
	input wire logic [7:0]        rdData,
	input wire logic              intervalOverflowIrq,
	input wire logic              chipResetOut_b,
	input wire logic              resetOutPinOut,
	input wire logic              resetOutPinOe
);
	logic [9:0] lowCnt_r;
	logic [9:0] oeCnt_r;
	// Access decode, ignored while the chip is held in reset
	wire logic       wrC = cpuBus.wrWord && cpuBus.addr == pgw_pkg::ADDR_CTRL_WR && chipResetOut_b;
	wire logic       wrE = cpuBus.wrWord && cpuBus.addr == pgw_pkg::ADDR_RST_WR && chipResetOut_b;
	wire logic       rdOk = cpuBus.rdByte && chipResetOut_b;
	wire logic [7:0] pw = cpuBus.wdata[15:8];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Length of the current low or high pulse
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_r <= 10'h000;
			oeCnt_r  <= 10'h000;
		end else begin
			lowCnt_r <= chipResetOut_b ? 10'h000 : lowCnt_r + 10'h001;
			oeCnt_r  <= resetOutPinOe ? oeCnt_r + 10'h001 : 10'h000;
		end
	end

	pin_level_a: assert property (resetOutPinOut == 1'b0) else $error("pin level");
	chip_rst_len_a: assert property (
		$rose(chipResetOut_b) |-> lowCnt_r == pgw_pkg::CHIP_RESET_CNT)
		else $error("chip reset length");
	pin_len_a: assert property (
		$fell(resetOutPinOe) |-> oeCnt_r == pgw_pkg::PIN_RESET_CNT)
		else $error("pin pulse length");
	pin_start_a: assert property ($rose(resetOutPinOe) |-> $fell(chipResetOut_b))
		else $error("pin pulse start");
	irq_pulse_a: assert property (intervalOverflowIrq |=> !intervalOverflowIrq)
		else $error("interrupt pulse");
	ctrl_write_a: assert property (
		wrC && pw == pgw_pkg::PASS_CTRL ##2 rdOk && cpuBus.addr == pgw_pkg::ADDR_CTRL_RD
		|=> rdData[6:0] == ($past(cpuBus.wdata[6:0], 3) | 7'h18)) else $error("control write");
	cnt_write_a: assert property (
		wrC && pw == pgw_pkg::PASS_CNT ##2 rdOk && cpuBus.addr == pgw_pkg::ADDR_CNT_RD
		|=> 8'(rdData - $past(cpuBus.wdata[7:0], 3)) <= 8'h02) else $error("counter write");
	flag_clear_a: assert property (
		wrE && cpuBus.wdata == 16'hA500 ##2 rdOk && cpuBus.addr == pgw_pkg::ADDR_RST_RD
		|=> !rdData[7]) else $error("flag clear");
	oe_write_a: assert property (
		wrE && pw == pgw_pkg::PASS_CNT ##2 rdOk && cpuBus.addr == pgw_pkg::ADDR_RST_RD
		|=> rdData[6] == $past(cpuBus.wdata[6], 3)) else $error("output enable write");
endmodule

bind pgw_watchdog pgw_watchdog_properties pgw_watchdog_properties_inst (.clk(clk), .rst_b(rst_b),
	.cpuBus(cpuBus), .rdData(rdData), .intervalOverflowIrq(intervalOverflowIrq),
	.chipResetOut_b(chipResetOut_b), .resetOutPinOut(resetOutPinOut), .resetOutPinOe(resetOutPinOe));

//--- testbench.sv
// Purpose: Self checking bench of the watchdog
// Assumes: CPU model issues every access
// Notes:   Expected values built from the register layout
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end \
end
module testbench;
	logic              clk;
	logic              rst_b;
	pgw_pkg::pgw_bus_t cpuBus;
	logic [7:0]        rdData;
	logic              irq;
	logic              chipRst_b;
	logic              pinOut;
	logic              pinOe;
	int                errors = 0;
	int                cmp_count = 0;

	pgw_watchdog pgw_watchdog_inst (.clk(clk), .rst_b(rst_b), .cpuBus(cpuBus), .rdData(rdData),
		.intervalOverflowIrq(irq), .chipResetOut_b(chipRst_b), .resetOutPinOut(pinOut),
		.resetOutPinOe(pinOe));
	pgw_cpu_model pgw_cpu_model_inst (.clk(clk), .rdData(rdData), .cpuBus(cpuBus));

	// Clock of 8 ns
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Write to the timer address or the reset status address
	task automatic wr(input logic rs, input logic [15:0] d);
		pgw_cpu_model_inst.wr(rs ? pgw_pkg::ADDR_RST_WR : pgw_pkg::ADDR_CTRL_WR, d);
	endtask

	// Read at offset 0, 1 or 3 and compare
	task automatic rdChk(input logic [1:0] o, input logic [7:0] e);
		logic [7:0] v;
		pgw_cpu_model_inst.rd(pgw_pkg::ADDR_CTRL_RD + 20'(o), v);
		`CHK("rdData", e, v)
	endtask

	task automatic t_reset;
		rdChk(2'h0, 8'h18);
		rdChk(2'h1, 8'h00);
		rdChk(2'h3, 8'h3F);
		wr(1'b0, 16'h1234);
		rdChk(2'h0, 8'h18);
		wr(1'b1, 16'h1240);
		rdChk(2'h3, 8'h3F);
		$display("test reset_and_password done");
	endtask

	task automatic t_interval;
		int n;
		wr(1'b0, 16'hA527);
		wr(1'b0, 16'h5A80);
		rdChk(2'h1, 8'h80);
		wr(1'b0, 16'hA507); // Halt before the clock change
		wr(1'b0, 16'hA520);
		wr(1'b0, 16'h5AFF);
		n = 0;
		while (irq !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		`CHK("irq", 1'b1, irq)
		if (irq !== 1'b1) end_of_test();
		rdChk(2'h0, 8'hB8);
		wr(1'b0, 16'hA5A0);
		rdChk(2'h0, 8'hB8);
		wr(1'b0, 16'hA520);
		rdChk(2'h0, 8'h38);
		rdChk(2'h3, 8'h3F);
		wr(1'b0, 16'hA500);
		rdChk(2'h1, 8'h00);
		$display("test interval done");
	endtask

	// Clock-select codes 1 to 7: two counter steps from FE take more than one period
	task automatic t_divider;
		int divOf[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
		int n;
		for (int c = 1; c < 8; c++) begin
			wr(1'b0, 16'hA500); // Halt before the clock change
			wr(1'b0, 16'hA520 | 16'(c));
			wr(1'b0, 16'h5AFE);
			n = 0;
			while (irq !== 1'b1 && n < 2 * divOf[c] + 8) begin
				@(posedge clk);
				n++;
			end
			`CHK("divider", 1'b1, n > divOf[c] && n <= 2 * divOf[c])
		end
		wr(1'b0, 16'hA500);
		$display("test divider done");
	endtask

	// Overflow with the pin disabled, then a pin reset clears the watchdog flag
	task automatic t_pin_reset;
		int n;
		int lo;
		int oe;
		wr(1'b1, 16'h5A00);
		rdChk(2'h3, 8'h3F);
		wr(1'b0, 16'hA560);
		wr(1'b0, 16'h5AF0);
		n = 0;
		lo = 0;
		oe = 0;
		while (chipRst_b !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		while (chipRst_b === 1'b0 && lo < 600) begin
			oe += (pinOe === 1'b1);
			@(posedge clk);
			lo++;
		end
		`CHK("chipLow", 518, lo)
		`CHK("pinOff", 0, oe)
		rdChk(2'h3, 8'hBF);
		rst_b <= 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rdChk(2'h3, 8'h3F);
		rdChk(2'h0, 8'h18);
		$display("test pin_reset done");
	endtask

	task automatic t_watchdog;
		int n;
		int lo;
		int oe;
		wr(1'b1, 16'h5A40);
		rdChk(2'h3, 8'h7F);
		wr(1'b0, 16'hA560);
		wr(1'b0, 16'h5A00); // Refresh before overflow
		wr(1'b0, 16'h5AF0);
		n = 0;
		lo = 0;
		oe = 0;
		while (chipRst_b !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		while (chipRst_b === 1'b0 && lo < 600) begin
			oe += (pinOe === 1'b1);
			@(posedge clk);
			lo++;
		end
		`CHK("chipLow", 518, lo)
		`CHK("pinLow", 132, oe)
		rdChk(2'h3, 8'hFF);
		rdChk(2'h0, 8'h18);
		wr(1'b1, 16'hA500);
		rdChk(2'h3, 8'h7F);
		$display("test watchdog done");
	endtask

	// Reset, then the scenarios
	initial begin
		rst_b = 1'b0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_interval();
		t_divider();
		t_watchdog();
		t_pin_reset();
		end_of_test();
	end
endmodule
